// ===== verilog/ccpmc_map.vh
// Register map, field positions and constants for the capture/compare mode control block
`ifndef CCPMC_MAP_VH
`define CCPMC_MAP_VH
// Register byte offsets (base, clear, set, invert aliases)
`define CCPMC_CON1_BASE 8'h00
`define CCPMC_CON2_BASE 8'h10
`define CCPMC_STAT_ADDR 8'h20
`define CCPMC_ALIAS_CLR 2'h1
`define CCPMC_ALIAS_SET 2'h2
`define CCPMC_ALIAS_INV 2'h3
// Writable bit masks (unimplemented bits stay zero)
`define CCPMC_CON1_MASK 32'hcfffbfff
`define CCPMC_CON2_MASK 32'hbfdfd0ff
`define CCPMC_CON1_RST 32'h00000000
`define CCPMC_CON2_RST 32'h01000000
// Control-one field positions
`define CCPMC_POSTSCALE_SOURCE_SEL 31
`define CCPMC_RTRG 30
`define CCPMC_OPS_HI 27
`define CCPMC_OPS_LO 24
`define CCPMC_TRIG 23
`define CCPMC_SHOT 22
`define CCPMC_ALTS 21
`define CCPMC_SYNC_HI 20
`define CCPMC_SYNC_LO 16
`define CCPMC_ON 15
`define CCPMC_STOP_IN_IDLE 13
`define CCPMC_SLP 12
`define CCPMC_TSYNC 11
`define CCPMC_CLK_HI 10
`define CCPMC_CLK_LO 8
`define CCPMC_PS_HI 7
`define CCPMC_PS_LO 6
`define CCPMC_T32 5
`define CCPMC_CAPTURE_SELECT 4
`define CCPMC_MOD_HI 3
`define CCPMC_MOD_LO 0
// Control-two capture source field
`define CCPMC_ICS_HI 18
`define CCPMC_ICS_LO 16
// Sync source codes
`define CCPMC_SYNC_NONE 5'h00
`define CCPMC_SYNC_FREE 5'h1f
`define CCPMC_SYNC_SELF 5'h01
`define CCPMC_SYNC_SIB_HI 5'h04
`define CCPMC_SYNC_INT_LO 5'h09
`define CCPMC_SYNC_INT_HI 5'h0d
`define CCPMC_SYNC_LC1 5'h10
`define CCPMC_SYNC_LC2 5'h11
`define CCPMC_SYNC_CMP1 5'h18
`define CCPMC_SYNC_CMP2 5'h19
`define CCPMC_SYNC_ADC 5'h1b
// Compare mode codes
`define CCPMC_MOD_TIMER 4'h0
`define CCPMC_MOD_HIGH 4'h1
`define CCPMC_MOD_LOW 4'h2
`define CCPMC_MOD_TOG 4'h3
`define CCPMC_MOD_DUAL 4'h4
`define CCPMC_MOD_EXT 4'hf
// Capture mode codes
`define CCPMC_CAP_EDGE 4'h0
`define CCPMC_CAP_RISE 4'h1
`define CCPMC_CAP_FALL 4'h2
`define CCPMC_CAP_BOTH 4'h3
`define CCPMC_CAP_R4 4'h4
`define CCPMC_CAP_R16 4'h5
// Counter limits
`define CCPMC_MAX16 32'h0000ffff
`define CCPMC_MAX32 32'hffffffff
`define CCPMC_ONE32 32'h00000001
`define CCPMC_ZERO32 32'h00000000
`define CCPMC_ONE4 4'h1
`define CCPMC_ZERO4 4'h0
`define CCPMC_ONE6 6'h01
`define CCPMC_ZERO6 6'h00
`define CCPMC_PS4 6'h03
`define CCPMC_PS16 6'h0f
`define CCPMC_PS64 6'h3f
`define CCPMC_CAP4 4'h3
`define CCPMC_CAP16 4'hf
`define CCPMC_SHOT_SCALE 3'h1
`define CCPMC_RESP_OK 2'h0
`define CCPMC_RESP_ERR 2'h2
`endif

// ===== verilog/ccpmc_top.v
// Capture/compare/PWM mode and time-base control with AXI4-Lite registers
`timescale 1ns/1ps
// Functional notes
// (R01) Clear, set, invert aliases at +4,+8,+C
// (R02) Postscaler counts trigger or period events; code counts captures in capture mode, else rollovers, or rollovers with the sync output when selected
// (R03) Retrigger restarts time base while triggered
// (R04) Interrupt every N+1 matches or captures
// (R05) Software keeps postscale small in capture
// (R06) Triggered mode waits for sync source
// (R07) One-shot stops time base after count
// (R08) Sync output: alternate or rollover event
// (R09) Code all ones free-runs to maximum
// (R10) Code zero: roll at max or period
// (R11) Other codes reset on selected source
// (R12) Module enable gates selected mode
// (R13) Stop in idle halts module
// (R14) Sleep enable keeps module running
// (R15) Clock sync resamples time base clock
// (R16) Clock select picks time base source
// (R17) Prescale divides by 1,4,16,64
// (R18) Wide select uses 32-bit time base
// (R19) Capture select picks capture modes
// (R20) Capture codes choose capturing edges
// (R21) Compare codes drive high, low, toggle
// (R22) Dual edge, PWM, pulse modes provided
// (R23) External mode passes selected source
// (R24) Unimplemented bits read zero
`include "ccpmc_map.vh"
module ccpmc_top (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address and data
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Device power state
  input wire dev_idle,
  input wire dev_sleep,
  // Time base clock sources, sampled as levels
  input wire reference_clock_output,
  input wire secondary_oscillator,
  input wire logic_cell_clk,
  input wire ext_timer_clock_a,
  input wire ext_timer_clock_b,
  // Sync sources: [0] self, [1..3] siblings
  input wire [3:0] sib_sync_in,
  input wire [4:0] ext_int_in,
  input wire [1:0] comparator_in,
  input wire [1:0] logic_cell_in,
  input wire adc_start_in,
  input wire alt_sync_in,
  // Capture inputs and external sources
  input wire capture_pin,
  input wire [5:0] ext_source_in,
  input wire [31:0] period_val,
  input wire [31:0] compare_a_val,
  input wire [31:0] compare_b_val,
  // Outputs
  output reg [31:0] timebase_out,
  output reg compare_out,
  output reg sync_out,
  output reg capture_strobe,
  output reg postscale_event,
  output reg triggered_status_flag,
  output reg module_active
);
  // Control registers and status
  reg [31:0] con1_reg;
  reg [31:0] con2_reg;
  reg [31:0] tmr_reg;
  reg [5:0] ps_reg;
  reg [3:0] ops_cnt_reg;
  reg [3:0] cap_cnt_reg;
  reg [2:0] shot_reg;
  reg clk_sync_reg;
  reg clk_prev_reg;
  reg cap_prev_reg;
  // Bus slave holding registers
  reg aw_hold_reg;
  reg w_hold_reg;
  reg [7:0] awaddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;

  // Field views
  wire [3:0] mode_sel = con1_reg[`CCPMC_MOD_HI:`CCPMC_MOD_LO];
  wire [4:0] sync_sel = con1_reg[`CCPMC_SYNC_HI:`CCPMC_SYNC_LO];
  wire [2:0] clk_sel = con1_reg[`CCPMC_CLK_HI:`CCPMC_CLK_LO];
  wire [1:0] ps_sel = con1_reg[`CCPMC_PS_HI:`CCPMC_PS_LO];
  wire [3:0] ops_sel = con1_reg[`CCPMC_OPS_HI:`CCPMC_OPS_LO];
  wire [2:0] ics_sel = con2_reg[`CCPMC_ICS_HI:`CCPMC_ICS_LO];
  wire cap_mode = con1_reg[`CCPMC_CAPTURE_SELECT];

  // Byte-lane merge with alias operation
  function [31:0] alias_apply;
    input [31:0] cur;
    input [31:0] wd;
    input [3:0] strb;
    input [1:0] op;
    input [31:0] mask;
    reg [31:0] bm;
    reg [31:0] res;
    begin
      bm = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & wd;
      case (op)
        `CCPMC_ALIAS_CLR: res = cur & ~bm;
        `CCPMC_ALIAS_SET: res = cur | bm;
        `CCPMC_ALIAS_INV: res = cur ^ bm;
        default:
          res = (cur & ~{{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}}) | bm;
      endcase
      alias_apply = res & mask;
    end
  endfunction

  // Runs only when enabled and not halted by power state
  wire run = con1_reg[`CCPMC_ON] & ~(dev_idle & con1_reg[`CCPMC_STOP_IN_IDLE])
    & ~(dev_sleep & ~con1_reg[`CCPMC_SLP]); // see (R12) see (R13) see (R14)

  // Clock source mux
  reg src_clk;
  always @*
  begin
    case (clk_sel) // see (R16)
      3'h0: src_clk = 1'b1;
      3'h1: src_clk = reference_clock_output;
      3'h2: src_clk = secondary_oscillator;
      3'h3: src_clk = logic_cell_clk;
      3'h6: src_clk = ext_timer_clock_b;
      3'h7: src_clk = ext_timer_clock_a;
      default: src_clk = 1'b0; // Reserved: no ticks
    endcase
  end

  // Rising edge of the selected source; sync adds a stage of latency
  wire src_lvl = con1_reg[`CCPMC_TSYNC] ? clk_sync_reg : src_clk; // see (R15)
  wire src_tick = (clk_sel == 3'h0) ? 1'b1 : (src_lvl & ~clk_prev_reg);

  // Prescale terminal count
  reg [5:0] ps_term;
  always @*
  begin
    case (ps_sel) // see (R17)
      2'h1: ps_term = `CCPMC_PS4;
      2'h2: ps_term = `CCPMC_PS16;
      2'h3: ps_term = `CCPMC_PS64;
      default: ps_term = `CCPMC_ZERO6;
    endcase
  end
  wire tb_tick = run & src_tick & (ps_reg == ps_term);

  // Synchronisation source select
  reg sync_hit;
  always @*
  begin
    sync_hit = 1'b0;
    if (sync_sel >= `CCPMC_SYNC_SELF && sync_sel <= `CCPMC_SYNC_SIB_HI) // see (R11)
      sync_hit = sib_sync_in[sync_sel[1:0] - 2'h1];
    else if (sync_sel >= `CCPMC_SYNC_INT_LO && sync_sel <= `CCPMC_SYNC_INT_HI)
      sync_hit = ext_int_in[sync_sel[2:0] - 3'h1];
    else if (sync_sel == `CCPMC_SYNC_LC1)
      sync_hit = logic_cell_in[0];
    else if (sync_sel == `CCPMC_SYNC_LC2)
      sync_hit = logic_cell_in[1];
    else if (sync_sel == `CCPMC_SYNC_CMP1)
      sync_hit = comparator_in[0];
    else if (sync_sel == `CCPMC_SYNC_CMP2)
      sync_hit = comparator_in[1];
    else if (sync_sel == `CCPMC_SYNC_ADC)
      sync_hit = adc_start_in;
  end

  // Rollover point: free-run ignores the period
  wire [31:0] tmax = con1_reg[`CCPMC_T32] ? `CCPMC_MAX32 : `CCPMC_MAX16; // see (R18)
  wire at_max = (tmr_reg == tmax);
  wire at_per = (tmr_reg == period_val) & (sync_sel != `CCPMC_SYNC_FREE); // see (R09)
  wire roll = tb_tick & (at_max | at_per); // see (R10)
  wire trig_mode = con1_reg[`CCPMC_TRIG];
  // Retrigger only honoured with retrigger enable
  wire trig_start = trig_mode & sync_hit
    & (~triggered_status_flag | con1_reg[`CCPMC_RTRG]); // see (R03) see (R06)
  wire sync_reset = ~trig_mode & sync_hit; // see (R11)
  wire counting = trig_mode ? triggered_status_flag : 1'b1;

  // Capture edge detection
  wire rise = capture_pin & ~cap_prev_reg;
  wire fall = ~capture_pin & cap_prev_reg;
  reg cap_ev;
  reg [3:0] cap_div;
  always @*
  begin
    cap_div = `CCPMC_ZERO4;
    case (mode_sel) // see (R20)
      `CCPMC_CAP_EDGE, `CCPMC_CAP_BOTH: cap_ev = rise | fall;
      `CCPMC_CAP_RISE: cap_ev = rise;
      `CCPMC_CAP_FALL: cap_ev = fall;
      `CCPMC_CAP_R4:
      begin
        cap_ev = rise;
        cap_div = `CCPMC_CAP4;
      end
      `CCPMC_CAP_R16:
      begin
        cap_ev = rise;
        cap_div = `CCPMC_CAP16;
      end
      default: cap_ev = 1'b0; // Reserved codes capture nothing
    endcase
  end
  wire cap_fire = run & cap_mode & cap_ev & (cap_cnt_reg == cap_div); // see (R19)

  // Postscaler input: captures, or rollovers (gated by the sync output when source select is set)
  wire sync_out_next = con1_reg[`CCPMC_ALTS] ? alt_sync_in : roll; // see (R08)
  wire ps_src_ev = cap_mode ? cap_fire
    : (con1_reg[`CCPMC_POSTSCALE_SOURCE_SEL] ? (roll & sync_out_next) : roll); // see (R02)

  // Compare output next value
  reg cmp_next;
  always @*
  begin
    cmp_next = compare_out;
    if (!run || cap_mode)
      cmp_next = 1'b0;
    else
    begin
      case (mode_sel) // see (R21) see (R22)
        `CCPMC_MOD_TIMER: cmp_next = 1'b0;
        `CCPMC_MOD_HIGH: if (tmr_reg == compare_a_val) cmp_next = 1'b1;
        `CCPMC_MOD_LOW: if (tmr_reg == compare_a_val) cmp_next = 1'b0;
        `CCPMC_MOD_TOG: if (tb_tick && tmr_reg == compare_a_val) cmp_next = ~compare_out;
        4'h4, 4'h5, 4'h6: cmp_next = (tmr_reg >= compare_a_val) & (tmr_reg < compare_b_val);
        4'h7: if (tb_tick && tmr_reg == compare_a_val) cmp_next = ~compare_out;
        `CCPMC_MOD_EXT: cmp_next = ext_source_in[ics_sel]; // see (R23)
        default: cmp_next = 1'b0; // Reserved
      endcase
    end
  end

  // Time base, prescaler, trigger and postscaler
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tmr_reg <= `CCPMC_ZERO32;
      ps_reg <= `CCPMC_ZERO6;
      ops_cnt_reg <= `CCPMC_ZERO4;
      cap_cnt_reg <= `CCPMC_ZERO4;
      shot_reg <= 3'h0;
      clk_sync_reg <= 1'b0;
      clk_prev_reg <= 1'b0;
      cap_prev_reg <= 1'b0;
      triggered_status_flag <= 1'b0;
      timebase_out <= `CCPMC_ZERO32;
      compare_out <= 1'b0;
      sync_out <= 1'b0;
      capture_strobe <= 1'b0;
      postscale_event <= 1'b0;
      module_active <= 1'b0;
    end
    else
    begin
      clk_sync_reg <= src_clk;
      clk_prev_reg <= src_lvl;
      cap_prev_reg <= capture_pin;
      module_active <= run;
      // Prescaler advances on every source edge while running
      if (run && src_tick)
        ps_reg <= (ps_reg == ps_term) ? `CCPMC_ZERO6 : ps_reg + `CCPMC_ONE6;
      // Trigger start beats a one-shot expiry
      if (!run)
        triggered_status_flag <= 1'b0;
      else if (trig_start)
      begin
        triggered_status_flag <= 1'b1;
        shot_reg <= con2_reg[29:27];
      end
      else if (roll && con1_reg[`CCPMC_SHOT] && triggered_status_flag)
      begin
        // One-shot: trigger lasts count+1 periods, then stops
        if (shot_reg == 3'h0)
          triggered_status_flag <= 1'b0; // see (R07)
        else
          shot_reg <= shot_reg - `CCPMC_SHOT_SCALE;
      end
      // Counter
      if (!run || trig_start || sync_reset)
        tmr_reg <= `CCPMC_ZERO32;
      else if (tb_tick && counting)
        tmr_reg <= roll ? `CCPMC_ZERO32 : tmr_reg + `CCPMC_ONE32;
      // Capture prescaler for every 4th/16th edge
      if (!run || !cap_mode)
        cap_cnt_reg <= `CCPMC_ZERO4;
      else if (cap_ev)
        cap_cnt_reg <= (cap_cnt_reg == cap_div) ? `CCPMC_ZERO4 : cap_cnt_reg + `CCPMC_ONE4;
      // Interrupt postscaler: fire every N+1 source events
      postscale_event <= 1'b0;
      if (!run)
        ops_cnt_reg <= `CCPMC_ZERO4;
      else if (ps_src_ev)
      begin
        if (ops_cnt_reg >= ops_sel) // see (R04)
        begin
          ops_cnt_reg <= `CCPMC_ZERO4;
          postscale_event <= 1'b1;
        end
        else
          ops_cnt_reg <= ops_cnt_reg + `CCPMC_ONE4;
      end
      capture_strobe <= cap_fire;
      sync_out <= run & sync_out_next;
      compare_out <= cmp_next;
      timebase_out <= con1_reg[`CCPMC_T32] ? tmr_reg : {16'h0000, tmr_reg[15:0]};
    end
  end

  // AXI4-Lite write path: address and data in either order
  wire wr_go = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
  wire [7:0] wbase = {awaddr_reg[7:4], 4'h0};
  wire [1:0] wop = awaddr_reg[3:2];
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      con1_reg <= `CCPMC_CON1_RST;
      con2_reg <= `CCPMC_CON2_RST;
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= `CCPMC_ZERO32;
      wstrb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CCPMC_RESP_OK;
    end
    else
    begin
      s_axi_awready <= ~aw_hold_reg & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready <= ~w_hold_reg & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `CCPMC_RESP_OK;
        if (wbase == `CCPMC_CON1_BASE) // see (R01)
          con1_reg <= alias_apply(con1_reg, wdata_reg, wstrb_reg, wop, `CCPMC_CON1_MASK);
        else if (wbase == `CCPMC_CON2_BASE)
          con2_reg <= alias_apply(con2_reg, wdata_reg, wstrb_reg, wop, `CCPMC_CON2_MASK);
        else if (awaddr_reg != `CCPMC_STAT_ADDR)
          s_axi_bresp <= `CCPMC_RESP_ERR; // Unmapped address
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // AXI4-Lite read path; aliases read back the base register
  wire [7:0] rbase = {s_axi_araddr[7:4], 4'h0};
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `CCPMC_ZERO32;
      s_axi_rresp <= `CCPMC_RESP_OK;
    end
    else
    begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `CCPMC_RESP_OK;
        if (rbase == `CCPMC_CON1_BASE)
          s_axi_rdata <= con1_reg; // see (R24)
        else if (rbase == `CCPMC_CON2_BASE)
          s_axi_rdata <= con2_reg;
        else if (s_axi_araddr == `CCPMC_STAT_ADDR)
          s_axi_rdata <= {26'h0, module_active, ops_cnt_reg[0], triggered_status_flag,
            compare_out, sync_out, capture_strobe};
        else
        begin
          s_axi_rdata <= `CCPMC_ZERO32;
          s_axi_rresp <= `CCPMC_RESP_ERR;
        end
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule // ccpmc_top

// ===== test/ccpmc_chk.sv
// Bus handshake and time base checks bound to the mode control block
`timescale 1ns/1ps
module ccpmc_chk (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Time base
  input wire logic [31:0] timebase_out,
  input wire logic module_active
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  chk_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready held past one cycle");
  chk_w_pulse: assert property (s_axi_wready |=> !s_axi_wready)
    else $error("wready held past one cycle");
  chk_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("arready held past one cycle");
  chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  chk_aw_answer: assert property (s_axi_awready |-> ##[1:3] s_axi_bvalid)
    else $error("write response missing");
  chk_ar_answer: assert property (s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  chk_resp_legal: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2)
    else $error("illegal write response code");
  chk_off_hold: assert property (!module_active [*3] |-> $stable(timebase_out))
    else $error("time base moved while inactive");
  chk_step_one: assert property (timebase_out != 32'h0 && $changed(timebase_out) |-> timebase_out == $past(timebase_out) + 32'h1)
    else $error("time base jumped");
endmodule // ccpmc_chk
bind ccpmc_top ccpmc_chk u_chk (.*);

// ===== test/ccpmc_far_end.sv
// Far-side model: clock source levels, sync sources and capture pin
`timescale 1ns/1ps
module ccpmc_far_end (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bench command
  input wire logic [4:0] pulse_code,
  input wire logic pulse_go,
  // Clock source levels
  output logic reference_clock_output,
  output logic secondary_oscillator,
  output logic logic_cell_clk,
  output logic ext_timer_clock_a,
  output logic ext_timer_clock_b,
  // Sync sources and capture input
  output logic [3:0] sib_sync_in,
  output logic [4:0] ext_int_in,
  output logic [1:0] comparator_in,
  output logic [1:0] logic_cell_in,
  output logic adc_start_in,
  output logic alt_sync_in,
  output logic capture_pin
);
  logic [7:0] cnt_reg; // Free divider for the sources
  logic [31:0] hit_reg; // One-hot sync pulse, indexed by code
  // Sources run free; a sync pulse lasts one cycle
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_reg <= 8'h00;
      hit_reg <= 32'h00000000;
    end
    else
    begin
      cnt_reg <= cnt_reg + 8'h01;
      hit_reg <= pulse_go ? (32'h00000001 << pulse_code) : 32'h00000000;
    end
  end
  // Rates 1/4, 1/16, 1/8, 1/8, 1/16 of the system clock
  assign reference_clock_output = cnt_reg[1];
  assign secondary_oscillator = cnt_reg[3];
  assign logic_cell_clk = cnt_reg[2];
  assign ext_timer_clock_a = cnt_reg[2];
  assign ext_timer_clock_b = cnt_reg[3];
  assign sib_sync_in = hit_reg[4:1];
  assign ext_int_in = hit_reg[13:9];
  assign logic_cell_in = hit_reg[17:16];
  assign comparator_in = hit_reg[25:24];
  assign adc_start_in = hit_reg[27];
  assign alt_sync_in = cnt_reg[4];
  assign capture_pin = cnt_reg[5];
endmodule // ccpmc_far_end

// ===== test/tb.sv
// Self-checking bench for the capture/compare mode control block
`timescale 1ns/1ps
module tb;
  // Clock, reset, power state and values
  logic aclk = 1'b0, aresetn = 1'b0, dev_idle = 1'b0, dev_sleep = 1'b0;
  logic [31:0] period_val = 32'h3, compare_a_val = 32'h2, compare_b_val = 32'h0;
  logic [5:0] ext_source_in = 6'h00;
  // Bus master side
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, timebase_out;
  // Block outputs and far-side lines
  logic compare_out, sync_out, capture_strobe, postscale_event;
  logic triggered_status_flag, module_active, adc_start_in, alt_sync_in, capture_pin;
  logic reference_clock_output, secondary_oscillator, logic_cell_clk;
  logic ext_timer_clock_a, ext_timer_clock_b;
  logic [3:0] sib_sync_in;
  logic [4:0] ext_int_in, pulse_code = 5'h00;
  logic [1:0] comparator_in, logic_cell_in;
  logic pulse_go = 1'b0;
  int err_total = 0, comparisons = 0, g0 = 0;
  ccpmc_top dut (.*);
  ccpmc_far_end far (.*);
  // 100 MHz clock
  always #5 aclk = ~aclk;
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  // A bounded wait ran out
  task automatic stuck();
    cmp("bounded wait", 32'h1, 32'h0);
    finish_test();
  endtask
  task automatic run(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // One bus transfer; each request held until its ready
  task automatic bus(input bit w, input [7:0] a, input [31:0] d,
                     output [31:0] q, output [1:0] r);
    bit rs;
    rs = 1'b0;
    q = 32'h0;
    r = 2'h0;
    @(posedge aclk);
    if (w)
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end
    else
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    for (int n = 0; n < 40 && !rs; n++)
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if ((w && s_axi_bvalid === 1'b1) || (!w && s_axi_rvalid === 1'b1))
      begin
        rs = 1'b1;
        r = w ? s_axi_bresp : s_axi_rresp;
        q = s_axi_rdata;
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
      end
    end
    if (!rs) stuck();
  endtask
  task automatic wr(input [7:0] a, input [31:0] d);
    logic [31:0] q;
    logic [1:0] r;
    bus(1'b1, a, d, q, r);
  endtask
  task automatic rchk(input [7:0] a, input [31:0] e, input string nm);
    logic [31:0] q;
    logic [1:0] r;
    bus(1'b0, a, 32'h0, q, r);
    cmp(nm, e, q);
  endtask
  // Cycles between the last two of three interrupt pulses
  task automatic meas(output int g);
    int seen, last;
    seen = 0;
    last = 0;
    g = 0;
    for (int n = 0; n < 3000 && seen < 3; n++)
    begin
      @(posedge aclk);
      if (postscale_event === 1'b1)
      begin
        g = n - last;
        last = n;
        seen++;
      end
    end
    if (seen < 3) stuck();
  endtask
  task automatic fire(input [4:0] code);
    pulse_code <= code;
    pulse_go <= 1'b1;
    @(posedge aclk);
    pulse_go <= 1'b0;
  endtask
  task automatic t_regs();
    logic [31:0] q;
    logic [1:0] r;
    rchk(8'h00, 32'h00000000, "control one reset");
    rchk(8'h10, 32'h01000000, "control two reset");
    wr(8'h00, 32'hffffffff);
    rchk(8'h00, 32'hcfffbfff, "control one mask");
    wr(8'h10, 32'hffffffff);
    rchk(8'h10, 32'hbfdfd0ff, "control two mask");
    bus(1'b1, 8'h40, 32'hffffffff, q, r);
    cmp("unmapped write resp", 32'h2, r);
    bus(1'b0, 8'h44, 32'h0, q, r);
    cmp("unmapped read resp", 32'h2, r);
    wr(8'h10, 32'h01000000);
    $display("t_regs done");
  endtask
  // Clear, set and invert aliases, unimplemented bit untouched
  task automatic t_alias();
    wr(8'h00, 32'h00330f0f);
    wr(8'h04, 32'h00030003);
    wr(8'h08, 32'h40000010);
    wr(8'h0c, 32'h000040ff);
    rchk(8'h00, 32'h40300fe3, "alias result");
    wr(8'h18, 32'h00004000);
    rchk(8'h10, 32'h01004000, "control two set alias");
    wr(8'h10, 32'h01000000);
    $display("t_alias done");
  endtask
  // Prescale codes and clock sources scale the period gap
  task automatic t_clock();
    int g;
    logic [31:0] c [10] = '{0, 32'h40, 32'h80, 32'hc0, 32'h100, 32'h200, 32'h300,
                           32'h700, 32'h600, 32'h03000011};
    int f [10] = '{1, 4, 16, 64, 4, 16, 8, 8, 16, 64};
    period_val <= 32'h3;
    for (int i = 0; i < 10; i++)
    begin
      wr(8'h00, 32'h00008000 | c[i]);
      meas(g);
      if (i == 0) g0 = g;
      else cmp("period gap", g0 * f[i], g);
    end
    $display("t_clock done");
  endtask
  task automatic t_post();
    int g;
    int n [3] = '{1, 3, 15};
    for (int i = 0; i < 3; i++)
    begin
      wr(8'h00, 32'h00008000 | (n[i] << 24));
      meas(g);
      cmp("postscale gap", g0 * (n[i] + 1), g);
    end
    $display("t_post done");
  endtask
  // Free run passes the period value, code zero does not
  task automatic t_free();
    bit hit;
    for (int i = 0; i < 2; i++)
    begin
      wr(8'h00, i == 0 ? 32'h00008000 : 32'h001f8000);
      run(4);
      hit = 1'b0;
      repeat (30) @(posedge aclk) hit |= (timebase_out > period_val);
      cmp("count past period", i == 1, hit);
    end
    $display("t_free done");
  endtask
  task automatic t_power();
    logic [31:0] t0;
    logic [31:0] c [5] = '{32'h8000, 32'h9000, 32'h0, 32'ha000, 32'h8000};
    logic [1:0] p [5] = '{2'h1, 2'h2, 2'h0, 2'h1, 2'h2};
    bit m [5] = '{1, 1, 0, 0, 0};
    period_val <= 32'd200;
    for (int i = 0; i < 5; i++)
    begin
      wr(8'h00, c[i]);
      {dev_sleep, dev_idle} <= p[i];
      run(4);
      t0 = timebase_out;
      run(20);
      cmp("time base moving", m[i], t0 !== timebase_out);
      cmp("module active", m[i], module_active);
    end
    {dev_sleep, dev_idle} <= 2'h0;
    $display("t_power done");
  endtask
  task automatic t_cmp();
    logic last;
    int n;
    logic [3:0] md [4] = '{4'h1, 4'h2, 4'h3, 4'h0};
    bit lv [4] = '{1, 0, 0, 0};
    period_val <= 32'd9;
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h00, 32'h00008000 | md[i]);
      n = 0;
      last = compare_out;
      for (int k = 0; k < 40; k++)
      begin
        @(posedge aclk);
        n += (compare_out !== last);
        last = compare_out;
      end
      if (i == 2) cmp("toggle count", 1, n >= 2);
      else cmp("compare level", lv[i], compare_out);
    end
    $display("t_cmp done");
  endtask
  task automatic t_sync();
    logic [4:0] s [14] = '{1, 2, 3, 4, 9, 10, 11, 12, 13, 16, 17, 24, 25, 27};
    period_val <= 32'd255;
    for (int i = 0; i < 14; i++)
    begin
      wr(8'h00, 32'h00008000 | (s[i] << 16));
      run(30);
      fire(s[i]);
      run(3);
      cmp("sync restart", 1, timebase_out < 8);
    end
    $display("t_sync done");
  endtask
  // Triggered start, then retrigger while the flag is set
  task automatic t_trig();
    logic [31:0] t0;
    wr(8'h00, 32'h40818000);
    run(4);
    t0 = timebase_out;
    run(10);
    cmp("waiting time base", t0, timebase_out);
    cmp("flag before trigger", 0, triggered_status_flag);
    fire(5'h01);
    run(30);
    cmp("flag after trigger", 1, triggered_status_flag);
    cmp("running after trigger", 1, timebase_out > 8);
    fire(5'h01);
    run(3);
    cmp("retrigger restart", 1, timebase_out < 8);
    $display("t_trig done");
  endtask
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_alias();
    t_clock();
    t_post();
    t_free();
    t_power();
    t_cmp();
    t_sync();
    t_trig();
    finish_test();
  end
endmodule // tb
